/* File: sgm_core.sv */
// Overview of operation
// - Mode set captures A9..A0 and keeps it until reprogrammed.
// - Mode word: options A9-A7, latency A6-A4, wrap A3, length A2-A0.
// - Latency codes 1, 2, 3 select one to three clocks; others reserved.
// - Sequential lengths 1, 2, 4, 8 and full 256-column page; others reserved.
// - Interleave allows only lengths 4 and 8.
// - Sequential counts up wrapping in block; interleave xors start with count.
// - Options code 100 gives burst reads with single-word writes.
// - Special set with A6 high, A5 low loads data pins into color.
// - Special set with A5 high, A6 low loads data pins into mask.
// - A8 high on read or write closes the bank after the burst, after minimum row time.
// - Auto close offsets: read 0/-1/-1, write +1/+1/+2, block +2/+2/+3.
// - Write mask combines mask register and byte mask; byte mask wins.
// - Block write stores color into eight columns, data pins enable columns.
// - A9 picks the bank; A8 on precharge closes all banks.
`timescale 1ns/1ps
module sgm_core #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          cs_n,
  input  wire logic                          ras_n,
  input  wire logic                          cas_n,
  input  wire logic                          we_n,
  input  wire logic                          special_function_select,
  input  wire logic [sgm_pkg::ADDR_W-1:0]    addr,
  input  wire logic [sgm_pkg::DATA_W-1:0]    dq_in,
  input  wire logic [sgm_pkg::LANES-1:0]     dqm,
  input  wire logic                          arr_ready,
  output logic                               arr_valid,
  output logic [1:0]                         arr_kind,
  output logic                               arr_bank,
  output logic [sgm_pkg::COL_W-1:0]          arr_col,
  output logic [sgm_pkg::DATA_W-1:0]         arr_data,
  output logic [sgm_pkg::DATA_W-1:0]         arr_bitmask,
  output logic [sgm_pkg::DATA_W-1:0]         arr_colmask,
  output logic [1:0]                         pre_start,
  output logic [sgm_pkg::ADDR_W-1:0]         mode_cfg,
  output logic [1:0]                         latency_field,
  output logic                               mode_illegal,
  output logic [1:0]                         write_per_bit
);
  logic [sgm_pkg::ADDR_W-1:0] burst_mode_config_q;
  logic [sgm_pkg::DATA_W-1:0] block_fill_color_q;
  logic [sgm_pkg::DATA_W-1:0] bit_write_mask_q;
  logic [1:0]                 latency_q;
  logic                       illegal_q;
  logic [1:0]                 bmen_q;
  logic [1:0]                 pre_q;
  sgm_pkg::sgm_eng_t          eng_q;
  sgm_pkg::sgm_eng_t          eng_d;
  logic                       eng_bank_q;

  logic sel;
  logic mode_reg_set;
  logic special_reg_set;
  logic bank_activate;
  logic precharge;
  logic read_cmd;
  logic write_cmd;
  logic block_cmd;
  logic burst_halt;
  logic col_cmd;

  assign sel             = !cs_n;
  assign mode_reg_set    = sel && !ras_n && !cas_n && !we_n && !special_function_select;
  assign special_reg_set = sel && !ras_n && !cas_n && !we_n && special_function_select;
  assign bank_activate   = sel && !ras_n && cas_n && we_n;
  assign precharge       = sel && !ras_n && cas_n && !we_n && !special_function_select;
  assign read_cmd        = sel && ras_n && !cas_n && we_n && !special_function_select;
  assign write_cmd       = sel && ras_n && !cas_n && !we_n && !special_function_select;
  assign block_cmd       = sel && ras_n && !cas_n && !we_n && special_function_select;
  assign burst_halt      = sel && ras_n && cas_n && !we_n && !special_function_select;
  assign col_cmd         = read_cmd || write_cmd || block_cmd;

  // Mode word fields
  logic [2:0]                latency_code;
  logic                      wrap_order_bit;
  logic [2:0]                burst_len_field;
  logic                      single_write;
  logic [sgm_pkg::COL_W-1:0] len_mask;

  assign latency_code    = burst_mode_config_q[sgm_pkg::LAT_LSB +: 3];
  assign wrap_order_bit  = burst_mode_config_q[sgm_pkg::WRAP_BIT];
  assign burst_len_field = burst_mode_config_q[sgm_pkg::LEN_LSB +: 3];
  assign single_write    = burst_mode_config_q[sgm_pkg::OPT_LSB +: 3] == sgm_pkg::OPT_BRSW;

  function automatic logic mode_legal(input logic [sgm_pkg::ADDR_W-1:0] m);
    logic lat_ok;
    logic len_ok;
    lat_ok = m[sgm_pkg::LAT_LSB +: 3] >= sgm_pkg::LAT_1 && m[sgm_pkg::LAT_LSB +: 3] <= sgm_pkg::LAT_3;
    if (m[sgm_pkg::WRAP_BIT])
      len_ok = m[sgm_pkg::LEN_LSB +: 3] == sgm_pkg::LEN_4 || m[sgm_pkg::LEN_LSB +: 3] == sgm_pkg::LEN_8;
    else
      len_ok = m[sgm_pkg::LEN_LSB +: 3] <= sgm_pkg::LEN_8 || m[sgm_pkg::LEN_LSB +: 3] == sgm_pkg::LEN_PAGE;
    return lat_ok && len_ok;
  endfunction

  // Reserved codes fall back to single-word bursts
  always_comb
  begin
    case (burst_len_field)
      sgm_pkg::LEN_2:    len_mask = 8'h01;
      sgm_pkg::LEN_4:    len_mask = 8'h03;
      sgm_pkg::LEN_8:    len_mask = 8'h07;
      sgm_pkg::LEN_PAGE: len_mask = 8'hFF;
      default:           len_mask = 8'h00;
    endcase
    if (illegal_q)
      len_mask = 8'h00;
  end

  // Mode register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      burst_mode_config_q <= sgm_pkg::MODE_RST;
      latency_q           <= sgm_pkg::MODE_RST[sgm_pkg::LAT_LSB +: 2];
      illegal_q           <= 1'b0;
    end
    else if (mode_reg_set)
    begin
      burst_mode_config_q <= addr;
      latency_q           <= mode_legal(addr) ? addr[sgm_pkg::LAT_LSB +: 2] : 2'h0;
      illegal_q           <= !mode_legal(addr);
    end
  end

  // Color and mask registers; a load with both selects high changes neither
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      block_fill_color_q <= sgm_pkg::COLOR_RST;
      bit_write_mask_q   <= sgm_pkg::MASK_RST;
    end
    else if (special_reg_set)
    begin
      if (addr[sgm_pkg::COLOR_BIT] && !addr[sgm_pkg::MASK_BIT])
        block_fill_color_q <= dq_in;
      if (addr[sgm_pkg::MASK_BIT] && !addr[sgm_pkg::COLOR_BIT])
        bit_write_mask_q <= dq_in;
    end
  end

  // Burst engine
  logic                      multi;
  logic                      stop;
  logic                      eng_go;
  logic                      in_ready;
  logic [sgm_pkg::COL_W-1:0] seq_col;
  logic                      seq_last;

  assign multi  = (len_mask != 8'h00) && (read_cmd || (write_cmd && !single_write));
  assign stop   = (burst_halt && burst_len_field == sgm_pkg::LEN_PAGE && !illegal_q)
                || (precharge && (addr[sgm_pkg::AP_BIT] || addr[sgm_pkg::BANK_BIT] == eng_bank_q));
  assign eng_go = (eng_q != sgm_pkg::SGM_ENG_IDLE) && !col_cmd && !stop && in_ready;

  always_comb
  begin
    eng_d = eng_q;
    case (eng_q)
      sgm_pkg::SGM_ENG_IDLE:  eng_d = sgm_pkg::SGM_ENG_IDLE;
      sgm_pkg::SGM_ENG_READ,
      sgm_pkg::SGM_ENG_WRITE:
      begin
        if (stop || (eng_go && seq_last))
          eng_d = sgm_pkg::SGM_ENG_IDLE;
      end
      default:                eng_d = sgm_pkg::SGM_ENG_IDLE;
    endcase
    if (col_cmd)
      eng_d = !multi ? sgm_pkg::SGM_ENG_IDLE : (read_cmd ? sgm_pkg::SGM_ENG_READ : sgm_pkg::SGM_ENG_WRITE);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eng_q      <= sgm_pkg::SGM_ENG_IDLE;
      eng_bank_q <= 1'b0;
    end
    else
    begin
      eng_q <= eng_d;
      if (col_cmd)
        eng_bank_q <= addr[sgm_pkg::BANK_BIT];
    end
  end

  sgm_burst_seq #(
    .COL_W      (sgm_pkg::COL_W)
  ) u_seq (
    .clock      (clock),
    .rst_n      (rst_n),
    .load       (col_cmd && multi),
    .advance    (eng_go),
    .interleave (wrap_order_bit),
    .start      (addr[sgm_pkg::COL_W-1:0]),
    .len_mask   (len_mask),
    .col        (seq_col),
    .last       (seq_last)
  );

  // Write mask per byte lane: byte mask first, then bit mask if enabled
  logic                       op_bank;
  logic [sgm_pkg::DATA_W-1:0] wr_mask;
  assign op_bank = col_cmd ? addr[sgm_pkg::BANK_BIT] : eng_bank_q;
  for (genvar l = 0; l < sgm_pkg::LANES; l++)
  begin : g_lane
    assign wr_mask[l*8 +: 8] = dqm[l] ? 8'h00 : (bmen_q[op_bank] ? bit_write_mask_q[l*8 +: 8] : 8'hFF);
  end

  // Operation into the buffer
  sgm_stream_if #(.W(sgm_pkg::OP_W)) op_s ();
  sgm_pkg::sgm_op_t op;
  sgm_pkg::sgm_op_t head;
  logic             is_wr;

  always_comb
  begin
    op      = '0;
    op.bank = op_bank;
    if (col_cmd)
    begin
      op.kind = read_cmd ? sgm_pkg::SGM_OP_READ : (write_cmd ? sgm_pkg::SGM_OP_WRITE : sgm_pkg::SGM_OP_BLOCK);
      op.col  = block_cmd ? {addr[sgm_pkg::COL_W-1:3], 3'h0} : addr[sgm_pkg::COL_W-1:0];
    end
    else
    begin
      op.kind = (eng_q == sgm_pkg::SGM_ENG_READ) ? sgm_pkg::SGM_OP_READ : sgm_pkg::SGM_OP_WRITE;
      op.col  = seq_col;
    end
    is_wr = op.kind != sgm_pkg::SGM_OP_READ;
    if (block_cmd)
    begin
      op.data    = block_fill_color_q;
      op.colmask = dq_in;
    end
    else if (is_wr)
      op.data = dq_in;
    if (is_wr)
      op.bitmask = wr_mask;
  end

  assign op_s.valid = col_cmd || ((eng_q != sgm_pkg::SGM_ENG_IDLE) && !stop);
  assign op_s.data  = op;
  assign in_ready   = op_s.ready;

  sgm_fifo2 #(
    .W         (sgm_pkg::OP_W),
    .DEPTH     (BUF_DEPTH)
  ) u_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_s      (op_s.snk),
    .out_valid (arr_valid),
    .out_ready (arr_ready),
    .out_data  (head)
  );

  assign arr_kind    = head.kind;
  assign arr_bank    = head.bank;
  assign arr_col     = head.col;
  assign arr_data    = head.data;
  assign arr_bitmask = head.bitmask;
  assign arr_colmask = head.colmask;

  // Auto precharge delay from the command clock
  logic [sgm_pkg::AP_W-1:0] ap_delay;
  always_comb
  begin
    int blen;
    int d;
    d    = 0;
    blen = int'(len_mask) + 1;
    if (read_cmd)
      d = int'(latency_q) + blen - 1 + sgm_pkg::AP_RD_OFF[latency_q];
    else if (write_cmd)
      d = (single_write ? 1 : blen) - 1 + sgm_pkg::AP_WR_OFF[latency_q];
    else
      d = sgm_pkg::AP_BW_OFF[latency_q];
    if (d < 1)
      d = 1;
    ap_delay = sgm_pkg::AP_W'(d - 1);
  end

  // Per-bank row timing, bit-mask enable and precharge start
  logic [1:0] ras_ok;
  logic [1:0] ap_fire;
  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    logic [2:0]               ras_cnt_q;
    logic                     ap_pend_q;
    logic [sgm_pkg::AP_W-1:0] ap_cnt_q;
    logic                     hit;
    logic                     pre_hit;
    assign hit        = addr[sgm_pkg::BANK_BIT] == 1'(b);
    assign pre_hit    = precharge && (addr[sgm_pkg::AP_BIT] || hit);
    assign ras_ok[b]  = ras_cnt_q == 3'h0;
    assign ap_fire[b] = ap_pend_q && ap_cnt_q == '0 && ras_ok[b];
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ras_cnt_q <= 3'h0;
        ap_pend_q <= 1'b0;
        ap_cnt_q  <= '0;
        bmen_q[b] <= 1'b0;
        pre_q[b]  <= 1'b0;
      end
      else
      begin
        pre_q[b] <= pre_hit || ap_fire[b];
        if (bank_activate && hit)
          ras_cnt_q <= 3'(sgm_pkg::RAS_MIN_CYC);
        else if (ras_cnt_q != 3'h0)
          ras_cnt_q <= ras_cnt_q - 3'h1;
        if (bank_activate && hit)
          bmen_q[b] <= special_function_select;
        else if (pre_hit || ap_fire[b])
          bmen_q[b] <= 1'b0;
        if (col_cmd && hit && addr[sgm_pkg::AP_BIT])
        begin
          ap_pend_q <= 1'b1;
          ap_cnt_q  <= ap_delay;
        end
        else if (pre_hit || ap_fire[b])
          ap_pend_q <= 1'b0;
        else if (ap_cnt_q != '0)
          ap_cnt_q <= ap_cnt_q - 1'b1;
      end
    end
  end

  assign pre_start     = pre_q;
  assign mode_cfg      = burst_mode_config_q;
  assign latency_field = latency_q;
  assign mode_illegal  = illegal_q;
  assign write_per_bit = bmen_q;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic [sgm_pkg::COL_W-1:0] prev_col_q;
  logic                      prev_go_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_col_q <= '0;
      prev_go_q  <= 1'b0;
    end
    else
    begin
      prev_col_q <= op.col;
      prev_go_q  <= op_s.valid && in_ready;
    end
  end

  property p_mode_capture;
    mode_reg_set |=> mode_cfg == $past(addr);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("mode word not captured");

  property p_mode_hold;
    !mode_reg_set |=> $stable(mode_cfg) && $stable(latency_field);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode word changed without mode set");

  property p_latency;
    latency_field == (mode_illegal ? 2'h0 : mode_cfg[sgm_pkg::LAT_LSB +: 2]);
  endproperty
  a_latency: assert property (p_latency) else $error("latency decode wrong");

  property p_illegal;
    mode_illegal == !mode_legal(mode_cfg);
  endproperty
  a_illegal: assert property (p_illegal) else $error("reserved code flag wrong");

  property p_seq_order;
    eng_go && prev_go_q && !wrap_order_bit
      |-> op.col == ((prev_col_q & ~len_mask) | ((prev_col_q + 8'h01) & len_mask));
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("sequential column order wrong");

  property p_single_write;
    write_cmd && single_write |=> eng_q == sgm_pkg::SGM_ENG_IDLE;
  endproperty
  a_single_write: assert property (p_single_write) else $error("write burst in single write mode");

  property p_color;
    special_reg_set && addr[6] && !addr[5] |=> block_fill_color_q == $past(dq_in) && $stable(bit_write_mask_q);
  endproperty
  a_color: assert property (p_color) else $error("color load wrong");

  property p_mask;
    special_reg_set && addr[5] && !addr[6] |=> bit_write_mask_q == $past(dq_in) && $stable(block_fill_color_q);
  endproperty
  a_mask: assert property (p_mask) else $error("mask load wrong");

  property p_byte_mask;
    col_cmd && !read_cmd && dqm[0] |-> op.bitmask[7:0] == 8'h00;
  endproperty
  a_byte_mask: assert property (p_byte_mask) else $error("byte mask not honoured");

  property p_block;
    block_cmd |-> op.col[2:0] == 3'h0 && op.colmask == dq_in && op.data == block_fill_color_q;
  endproperty
  a_block: assert property (p_block) else $error("block write op wrong");

  property p_bw_ap_cl3;
    block_cmd && addr[8] && !addr[9] && latency_q == 2'h3 && ras_ok[0] && !precharge
      ##1 !(col_cmd || precharge) [*3] |=> pre_start[0];
  endproperty
  a_bw_ap_cl3: assert property (p_bw_ap_cl3) else $error("block auto close timing wrong");

  property p_tras;
    bank_activate && !addr[9] |=> !ap_fire[0] [*2];
  endproperty
  a_tras: assert property (p_tras) else $error("auto close before row time");

  property p_close_all;
    precharge && addr[8] |=> pre_start == 2'b11;
  endproperty
  a_close_all: assert property (p_close_all) else $error("close all missed a bank");

  c_mode_set: cover property (mode_reg_set ##1 !mode_illegal);
  c_full_page: cover property (eng_go && len_mask == 8'hFF);
  c_block_ap: cover property (block_cmd && addr[8] ##[1:8] pre_start[0]);
  c_buf_full: cover property (op_s.valid && !in_ready);
endmodule

/* File: sgm_pkg.sv */
package sgm_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RAS_MIN_NS  = 60;
  localparam int RAS_MIN_CYC   = (T_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int ADDR_W = 10;
  localparam int COL_W  = 8;
  localparam int DATA_W = 32;
  localparam int LANES  = 4;
  localparam int AP_W   = 9;

  // Mode word layout and codes
  localparam int OPT_LSB  = 7;
  localparam int LAT_LSB  = 4;
  localparam int WRAP_BIT = 3;
  localparam int LEN_LSB  = 0;
  localparam logic [2:0] OPT_BRSW = 3'h4;
  localparam logic [2:0] LAT_1    = 3'h1;
  localparam logic [2:0] LAT_3    = 3'h3;
  localparam logic [2:0] LEN_1    = 3'h0;
  localparam logic [2:0] LEN_2    = 3'h1;
  localparam logic [2:0] LEN_4    = 3'h2;
  localparam logic [2:0] LEN_8    = 3'h3;
  localparam logic [2:0] LEN_PAGE = 3'h7;

  // Address bits with a command meaning
  localparam int BANK_BIT  = 9;
  localparam int AP_BIT    = 8;
  localparam int COLOR_BIT = 6;
  localparam int MASK_BIT  = 5;

  // Reset values
  localparam logic [9:0]  MODE_RST  = 10'h020;
  localparam logic [31:0] COLOR_RST = 32'h00000000;
  localparam logic [31:0] MASK_RST  = 32'hFFFFFFFF;

  // Auto precharge offsets indexed by latency, relative to the last data clock
  localparam int AP_RD_OFF [4] = '{0, 0, -1, -1};
  localparam int AP_WR_OFF [4] = '{0, 1, 1, 2};
  localparam int AP_BW_OFF [4] = '{0, 2, 2, 3};

  typedef enum logic [1:0] {
    SGM_OP_READ  = 2'b00,
    SGM_OP_WRITE = 2'b01,
    SGM_OP_BLOCK = 2'b10
  } sgm_op_kind_t;

  typedef enum logic [1:0] {
    SGM_ENG_IDLE  = 2'b00,
    SGM_ENG_READ  = 2'b01,
    SGM_ENG_WRITE = 2'b10
  } sgm_eng_t;

  typedef struct packed {
    sgm_op_kind_t      kind;
    logic              bank;
    logic [COL_W-1:0]  col;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] bitmask;
    logic [DATA_W-1:0] colmask;
  } sgm_op_t;

  localparam int OP_W = $bits(sgm_op_t);

endpackage

/* File: sgm_stream_if.sv */
`timescale 1ns/1ps
interface sgm_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: sgm_fifo2.sv */
`timescale 1ns/1ps
module sgm_fifo2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  sgm_stream_if.snk         in_s,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [DEPTH-1:0] vld_q;
  logic [W-1:0]     mem_q [DEPTH];
  logic [DEPTH-1:0] sh_v;
  logic [W-1:0]     sh_m  [DEPTH];
  logic             push;
  logic             pop;

  assign in_s.ready = !vld_q[DEPTH-1];
  assign push       = in_s.valid && !vld_q[DEPTH-1];
  assign pop        = vld_q[0] && out_ready;
  assign out_valid  = vld_q[0];
  assign out_data   = mem_q[0];

  // Shift register: head entry always drives the output
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    if (i < DEPTH - 1)
    begin : g_mid
      assign sh_v[i] = pop ? vld_q[i+1] : vld_q[i];
      assign sh_m[i] = pop ? mem_q[i+1] : mem_q[i];
    end
    else
    begin : g_top
      assign sh_v[i] = pop ? 1'b0 : vld_q[i];
      assign sh_m[i] = mem_q[i];
    end
    logic wr_here;
    if (i == 0)
    begin : g_first
      assign wr_here = push && !sh_v[0];
    end
    else
    begin : g_rest
      assign wr_here = push && !sh_v[i] && sh_v[i-1];
    end
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        vld_q[i] <= 1'b0;
        mem_q[i] <= '0;
      end
      else
      begin
        vld_q[i] <= sh_v[i] || wr_here;
        mem_q[i] <= wr_here ? in_s.data : sh_m[i];
      end
    end
  end
endmodule

/* File: sgm_burst_seq.sv */
`timescale 1ns/1ps
module sgm_burst_seq #(
  parameter int COL_W = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic             advance,
  input  wire logic             interleave,
  input  wire logic [COL_W-1:0] start,
  input  wire logic [COL_W-1:0] len_mask,
  output logic      [COL_W-1:0] col,
  output logic                  last
);
  logic [COL_W-1:0] start_q;
  logic [COL_W-1:0] mask_q;
  logic [COL_W-1:0] count_q;
  logic             ilv_q;
  logic [COL_W-1:0] sum;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_q <= '0;
      mask_q  <= '0;
      count_q <= '0;
      ilv_q   <= 1'b0;
    end
    else if (load)
    begin
      start_q <= start;
      mask_q  <= len_mask;
      ilv_q   <= interleave;
      count_q <= COL_W'(1);
    end
    else if (advance)
    begin
      count_q <= count_q + COL_W'(1);
    end
  end

  // Sequential wraps inside the aligned block, interleave xors the word count
  assign sum  = start_q + count_q;
  assign col  = ilv_q ? (start_q ^ count_q) : ((start_q & ~mask_q) | (sum & mask_q));
  assign last = (count_q == mask_q);
endmodule

/* File: sgm_far_model.sv */
`timescale 1ns/1ps
module sgm_far_model (
  input  wire logic        clock,
  output logic [3:0]       cmd,
  output logic             special_function_select,
  output logic [9:0]       addr,
  output logic [31:0]      dq,
  output logic [3:0]       dqm
);
  // Pins stay still from time zero
  initial
  begin
    cmd = 4'hF;
    special_function_select = 1'b0;
    addr = 10'h000;
    dq = 32'h0;
    dqm = 4'h0;
  end
  // One command, then a deselect cycle; released data pins show the inverse
  task automatic issue(input logic [3:0] c, input logic [9:0] a, input logic [31:0] d, input logic [3:0] m);
    @(posedge clock);
    #5;
    cmd = {1'b0, c[3:1]};
    special_function_select = c[0];
    addr = a;
    dq = d;
    dqm = m;
    @(posedge clock);
    #5;
    cmd = 4'hF;
    dq = ~d;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst_n, arr_ready, special_function_select, arr_valid, arr_bank, mode_illegal;
  logic [3:0]  cmd, dqm;
  logic [9:0]  addr, mode_cfg;
  logic [31:0] dq, arr_data, arr_bitmask, arr_colmask;
  logic [7:0]  arr_col;
  logic [1:0]  arr_kind, pre_start, latency_field, write_per_bit;
  int          err_total, total_checks, cyc;
  sgm_far_model f (.clock(clock), .cmd(cmd), .special_function_select(special_function_select), .addr(addr),
    .dq(dq), .dqm(dqm));
  sgm_core DUT (.clock(clock), .rst_n(rst_n), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
    .special_function_select(special_function_select), .addr(addr), .dq_in(dq), .dqm(dqm), .arr_ready(arr_ready),
    .arr_valid(arr_valid), .arr_kind(arr_kind), .arr_bank(arr_bank), .arr_col(arr_col), .arr_data(arr_data),
    .arr_bitmask(arr_bitmask), .arr_colmask(arr_colmask), .pre_start(pre_start), .mode_cfg(mode_cfg),
    .latency_field(latency_field), .mode_illegal(mode_illegal), .write_per_bit(write_per_bit));
  always #25 clock = ~clock;
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_init;
    cmp("mode", 32'h20, {22'h0, mode_cfg});
    cmp("lat", 32'h2, {30'h0, latency_field});
    repeat (2000) @(posedge clock);
    f.issue(4'h4, 10'h100, 32'h0, 4'h0);
    cmp("pre", 32'h3, {30'h0, pre_start});
    f.issue(4'h2, 10'h000, 32'h0, 4'h0);
    f.issue(4'h2, 10'h000, 32'h0, 4'h0);
  endtask
  task automatic t_mode;
    logic [9:0] md [6] = '{10'h032, 10'h010, 10'h02F, 10'h000, 10'h029, 10'h027};
    logic [1:0] lt [6] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2};
    logic [5:0] il = 6'b011100;
    for (int i = 0; i < 6; i++)
    begin
      f.issue(4'h0, md[i], 32'h0, 4'h0);
      cmp("cfg", {22'h0, md[i]}, {22'h0, mode_cfg});
      cmp("ill", {31'h0, il[i]}, {31'h0, mode_illegal});
      if (!il[i])
        cmp("lat", {30'h0, lt[i]}, {30'h0, latency_field});
    end
  endtask
  task automatic t_burst(input logic [9:0] m, input logic [7:0] st, input int n, input logic [31:0] e);
    f.issue(4'h0, m, 32'h0, 4'h0);
    f.issue(4'h6, 10'h000, 32'h0, 4'h0);
    arr_ready = 1'b0;
    f.issue(4'hA, {2'b00, st}, 32'h0, 4'h0);
    for (int i = 0; i < n; i++)
    begin
      cmp("col", {24'h0, e[31-8*i -: 8]}, {24'h0, arr_col});
      arr_ready = 1'b1;
      @(posedge clock);
      #5;
      arr_ready = 1'b0;
    end
    cmp("end", 32'h0, {31'h0, arr_valid});
    arr_ready = 1'b1;
    f.issue(4'h4, 10'h000, 32'h0, 4'h0);
    cmp("pre", 32'h1, {30'h0, pre_start});
  endtask
  task automatic t_block;
    f.issue(4'h0, 10'h030, 32'h0, 4'h0);
    f.issue(4'h1, 10'h040, 32'hC01A5EED, 4'h0);
    f.issue(4'h1, 10'h020, 32'h0F0F0FFF, 4'h0);
    f.issue(4'h1, 10'h060, 32'h12345678, 4'h0);
    f.issue(4'h7, 10'h000, 32'h0, 4'h0);
    cmp("bmen", 32'h1, {30'h0, write_per_bit});
    @(posedge clock);
    #5;
    arr_ready = 1'b0;
    f.issue(4'h9, 10'h108, 32'h00FF0F81, 4'h0);
    cmp("kind", 32'h2, {30'h0, arr_kind});
    cmp("color", 32'hC01A5EED, arr_data);
    cmp("cols", 32'h00FF0F81, arr_colmask);
    cmp("bits", 32'h0F0F0FFF, arr_bitmask);
    cmp("pre0", 32'h0, {30'h0, pre_start});
    arr_ready = 1'b1;
    repeat (3) @(posedge clock);
    #5;
    cmp("pre1", 32'h1, {30'h0, pre_start});
  endtask
  task automatic t_write;
    f.issue(4'h0, 10'h232, 32'h0, 4'h0);
    f.issue(4'h7, 10'h200, 32'h0, 4'h0);
    cmp("bmen", 32'h2, {30'h0, write_per_bit});
    arr_ready = 1'b0;
    f.issue(4'h8, 10'h303, 32'hA5A5A5A5, 4'h1);
    cmp("kind", 32'h1, {30'h0, arr_kind});
    cmp("bank", 32'h1, {31'h0, arr_bank});
    cmp("data", 32'hA5A5A5A5, arr_data);
    cmp("bits", 32'h0F0F0F00, arr_bitmask);
    cmp("pre0", 32'h0, {30'h0, pre_start});
    arr_ready = 1'b1;
    repeat (2) @(posedge clock);
    #5;
    cmp("pre1", 32'h2, {30'h0, pre_start});
    cmp("one", 32'h0, {31'h0, arr_valid});
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      close_out;
    end
  end
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    arr_ready = 1'b1;
    repeat (12) @(posedge clock);
    #5;
    rst_n = 1'b1;
    t_init;
    t_mode;
    t_burst(10'h022, 8'h05, 4, 32'h05060704);
    t_burst(10'h02A, 8'h05, 4, 32'h05040706);
    t_burst(10'h021, 8'h01, 2, 32'h01000000);
    t_block;
    t_write;
    close_out;
  end
endmodule
